// [design/ewp_spi_prot.sv]
// spi eeprom write-protect, status register and serial sequencing
`timescale 1ns/100ps
`include "ewp_consts.svh"

// Function
// - latch must be set before writes complete
// - latch clears on power-up and completed writes
// - status readable anytime, even while busy
// - status layout: enable, x, protect, latch, busy
// - busy flag reflects write cycle, read-only
// - set/clear latch commands take effect even while busy
// - protect bits nonvolatile, status-write only
// - protect code selects locked array range
// - hardware protect needs pin low and enable
// - pin low during sequence refuses status write
// - started cycle ignores protect pin falling
// - latch clear locks array and status
// - write cycle starts only on select rise
// - array access during write cycle ignored
// - power-up standby, needs select fall first
// - deselect mid-cycle finishes cycle first
// - output floats while deselected
// - sample on clock rise, shift on fall
// - hold pauses at clock low without reset
// - paused: inputs ignored, output floats
// - resume only with hold rising, clock low
// - eight-bit instruction codes decoded
// - bits shifted most significant first
// - latch set only on select rise after op
module ewp_spi_prot #(
    parameter int TWC_CYCLES = `EWP_TWC_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       nv_rst_n,
    input  wire logic       cs_n_pin,
    input  wire logic       sck_pin,
    input  wire logic       si_pin,
    input  wire logic       hold_n_pin,
    input  wire logic       wp_n_pin,
    output logic            so_o,
    output logic            so_oe_n,
    output logic            arr_wr_go,
    output logic      [9:0] arr_wr_addr,
    output logic      [7:0] status_o
);
    import ewp_pkg::*;

    // ****************************************************
    // decode helpers
    // ****************************************************
    // status byte assembly
    function automatic logic [7:0] ewp_status(input logic pen, input logic [1:0] bp,
                                              input logic write_latch_flag, input logic busy_writing_flag);
        logic [7:0] s;
        s = 8'h00;
        s[`EWP_SR_PEN]  = pen;
        s[`EWP_SR_BPHI] = bp[1];
        s[`EWP_SR_BPLO] = bp[0];
        s[`EWP_SR_WEL]  = write_latch_flag;
        s[`EWP_SR_WIP]  = busy_writing_flag;
        return s;
    endfunction : ewp_status

    // array address locked by protect code
    function automatic logic ewp_blocked(input logic [1:0] bp, input logic [9:0] a);
        logic b;
        case (bp)
            2'h0:    b = 1'b0;
            2'h1:    b = (a >= `EWP_QUARTER_BASE);
            2'h2:    b = (a >= `EWP_HALF_BASE);
            default: b = 1'b1;
        endcase
        return b;
    endfunction : ewp_blocked

    // ****************************************************
    // pin synchronisers and edges
    // ****************************************************
    logic [4:0] pins_s;                  // synced {wp, hold, si, sck, cs}
    logic       cs_s, sck_s, si_s;       // synced pins
    logic       hold_s, wp_s;            // synced pins
    logic       sck_prev_q, cs_prev_q;   // edge detect history
    logic       sck_rise, sck_fall;      // clock edges
    logic       cs_rise, cs_fall;        // select edges
    logic       busy_writing_flag, wip_done;           // write cycle busy, end pulse

    ewp_sync u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin_i   ({wp_n_pin, hold_n_pin, si_pin, sck_pin, cs_n_pin}),
        .sync_o  (pins_s)
    );

    assign {wp_s, hold_s, si_s, sck_s, cs_s} = pins_s;
    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;
    assign cs_rise  = cs_s & ~cs_prev_q;
    assign cs_fall  = ~cs_s & cs_prev_q;

    // ****************************************************
    // sequence state
    // ****************************************************
    ewp_state_t st_q, st_d;            // sequence state
    logic       cs_act_q, cs_act_d;    // selected after a fall
    logic       paused_q, paused_d;    // hold pause
    logic [2:0] bcnt_q, bcnt_d;        // bit in byte
    logic [7:0] sh_q, sh_d;            // input shifter
    logic [7:0] cmd_q, cmd_d;          // latched instruction
    logic       cmpl_q, cmpl_d;        // complete command at a byte boundary
    logic       abyte_q, abyte_d;      // second address byte
    logic [9:0] addr_q, addr_d;        // array address
    logic [7:0] wsr_q, wsr_d;          // pending status value
    logic       swr_q, swr_d;          // cycle is a status write
    logic [2:0] ocnt_q, ocnt_d;        // output bit count
    logic [7:0] osh_q, osh_d;          // output shifter
    logic       so_q, so_d;            // output bit
    logic       drv_q, drv_d;          // output driving
    logic       wel_q, wel_d;          // write enable latch
    logic       wpseen_q, wpseen_d;    // protect pin low this sequence
    logic       go_q, go_d;            // write cycle start
    logic       pen_q, pen_d;          // nonvolatile pin enable
    logic [1:0] bp_q, bp_d;            // nonvolatile protect code
    logic [7:0] byte_in;               // completed input byte
    logic [7:0] stat;                  // live status byte
    logic       hw_prot;               // hardware protection active

    assign byte_in = {sh_q[6:0], si_s};
    assign stat    = ewp_status(pen_q, bp_q, wel_q, busy_writing_flag);
    assign hw_prot = pen_q & (wpseen_q | ~wp_s);

    // next values of the serial sequence
    always_comb begin
        st_d = st_q;  cs_act_d = cs_act_q;  paused_d = paused_q;
        bcnt_d = bcnt_q;  sh_d = sh_q;  cmd_d = cmd_q;  cmpl_d = cmpl_q;
        abyte_d = abyte_q;  addr_d = addr_q;  wsr_d = wsr_q;  swr_d = swr_q;
        ocnt_d = ocnt_q;  osh_d = osh_q;  so_d = so_q;  drv_d = drv_q;
        wel_d = wel_q;  wpseen_d = wpseen_q;  go_d = 1'b0;
        // completed cycle drops the latch
        if (wip_done) begin
            wel_d = 1'b0;
        end
        if (cs_fall) begin
            // a fall is needed before any sequence
            cs_act_d = 1'b1;
            st_d = EWP_S_OP;  bcnt_d = 3'h0;  cmpl_d = 1'b0;
            ocnt_d = 3'h0;  drv_d = 1'b0;  paused_d = 1'b0;
            wpseen_d = ~wp_s;
        end else if (cs_rise) begin
            // select rise ends the sequence; act on a full one
            cs_act_d = 1'b0;  st_d = EWP_S_STBY;  drv_d = 1'b0;  paused_d = 1'b0;
            if (cs_act_q && cmpl_q) begin
                case (cmd_q)
                    `EWP_OP_LATCH_SET:  wel_d = 1'b1;
                    `EWP_OP_LATCH_CLR:  wel_d = 1'b0;
                    `EWP_OP_STAT_WRITE: begin
                        // latch and hardware protection gate it
                        if (wel_q && !hw_prot && !busy_writing_flag) begin
                            go_d = 1'b1;
                            swr_d = 1'b1;
                        end
                    end
                    `EWP_OP_ARRAY_WRITE: begin
                        // locked range or clear latch refuses it
                        if (wel_q && !busy_writing_flag && !ewp_blocked(bp_q, addr_q)) begin
                            go_d = 1'b1;
                            swr_d = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end else if (cs_act_q) begin
            if (!wp_s) begin
                wpseen_d = 1'b1;
            end
            // pause and resume only while the clock is low
            if (!sck_s) begin
                paused_d = ~hold_s;
            end
            if (!paused_d && sck_rise) begin
                // capture on the rising clock edge
                sh_d = byte_in;
                bcnt_d = bcnt_q + 3'h1;
                cmpl_d = 1'b0;
                if (bcnt_q == 3'h7) begin
                    case (st_q)
                        EWP_S_OP: begin
                            cmd_d = byte_in;
                            case (byte_in)
                                `EWP_OP_LATCH_SET, `EWP_OP_LATCH_CLR: begin
                                    cmpl_d = 1'b1;
                                    st_d = EWP_S_SKIP;
                                end
                                `EWP_OP_STAT_READ:  st_d = EWP_S_RDST;
                                `EWP_OP_STAT_WRITE: st_d = EWP_S_WSR;
                                `EWP_OP_ARRAY_WRITE: begin
                                    // array access ignored while busy
                                    st_d = busy_writing_flag ? EWP_S_SKIP : EWP_S_ADR;
                                    abyte_d = 1'b0;
                                end
                                default: st_d = EWP_S_SKIP;
                            endcase
                        end
                        EWP_S_ADR: begin
                            if (!abyte_q) begin
                                addr_d[9:8] = byte_in[1:0];
                                abyte_d = 1'b1;
                            end else begin
                                addr_d[7:0] = byte_in;
                                st_d = EWP_S_WDAT;
                            end
                        end
                        EWP_S_WDAT: cmpl_d = 1'b1;
                        EWP_S_WSR: begin
                            wsr_d = byte_in;
                            cmpl_d = 1'b1;
                            st_d = EWP_S_SKIP;
                        end
                        default: ;
                    endcase
                end
            end
            if (!paused_d && sck_fall && st_q == EWP_S_RDST) begin
                // shift status out after the falling edge
                drv_d = 1'b1;
                ocnt_d = ocnt_q + 3'h1;
                if (ocnt_q == 3'h0) begin
                    so_d = stat[7];
                    osh_d = {stat[6:0], 1'b0};
                end else begin
                    so_d = osh_q[7];
                    osh_d = {osh_q[6:0], 1'b0};
                end
            end
        end
    end

    // registers of the serial sequence
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= EWP_S_STBY;  cs_act_q <= 1'b0;  paused_q <= 1'b0;
            bcnt_q <= 3'h0;  sh_q <= 8'h00;  cmd_q <= 8'h00;  cmpl_q <= 1'b0;
            abyte_q <= 1'b0;  addr_q <= 10'h000;  wsr_q <= 8'h00;  swr_q <= 1'b0;
            ocnt_q <= 3'h0;  osh_q <= 8'h00;  so_q <= 1'b0;  drv_q <= 1'b0;
            wel_q <= 1'b0;  wpseen_q <= 1'b0;  go_q <= 1'b0;
            sck_prev_q <= 1'b0;  cs_prev_q <= 1'b1;
        end else begin
            st_q <= st_d;  cs_act_q <= cs_act_d;  paused_q <= paused_d;
            bcnt_q <= bcnt_d;  sh_q <= sh_d;  cmd_q <= cmd_d;  cmpl_q <= cmpl_d;
            abyte_q <= abyte_d;  addr_q <= addr_d;  wsr_q <= wsr_d;  swr_q <= swr_d;
            ocnt_q <= ocnt_d;  osh_q <= osh_d;  so_q <= so_d;  drv_q <= drv_d;
            wel_q <= wel_d;  wpseen_q <= wpseen_d;  go_q <= go_d;
            sck_prev_q <= sck_s;  cs_prev_q <= cs_s;
        end
    end

    // ****************************************************
    // self-timed write cycle
    // ****************************************************
    // runs to its end whatever select or the pin do
    ewp_wtimer #(
        .CYCLES (TWC_CYCLES)
    ) u_wtimer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .go_i    (go_q),
        .busy_o  (busy_writing_flag),
        .done_o  (wip_done)
    );

    // ****************************************************
    // nonvolatile bits
    // ****************************************************
    // commit the pending byte as the status cycle ends
    always_comb begin
        pen_d = pen_q;
        bp_d  = bp_q;
        if (wip_done && swr_q) begin
            pen_d = wsr_q[`EWP_SR_PEN];
            bp_d  = {wsr_q[`EWP_SR_BPHI], wsr_q[`EWP_SR_BPLO]};
        end
    end

    // kept across power-up; only storage erase clears
    always_ff @(posedge sys_clk or negedge nv_rst_n) begin
        if (!nv_rst_n) begin
            pen_q <= `EWP_PEN_RST;
            bp_q  <= `EWP_BP_RST;
        end else begin
            pen_q <= pen_d;
            bp_q  <= bp_d;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    // float when deselected, paused or hold low
    assign so_oe_n     = ~(cs_act_q & ~paused_q & hold_s & drv_q);
    assign so_o        = so_q;
    assign arr_wr_go   = go_q & ~swr_q;
    assign arr_wr_addr = addr_q;
    assign status_o    = stat;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_done_op(logic [7:0] op);
        cs_rise && cs_act_q && cmpl_q && cmd_q == op;
    endsequence

    property p_latch_set;
        s_done_op(`EWP_OP_LATCH_SET) |=> wel_q;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set");

    property p_latch_clr;
        s_done_op(`EWP_OP_LATCH_CLR) |=> !wel_q;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");

    property p_start_on_rise;
        $rose(busy_writing_flag) |-> $past(cs_rise, 2) && $past(wel_q, 2);
    endproperty
    a_start_on_rise: assert property (p_start_on_rise) else $error("cycle start");

    property p_locked_range;
        s_done_op(`EWP_OP_ARRAY_WRITE) ##0 (ewp_blocked(bp_q, addr_q) && !busy_writing_flag) |=> ##1 !busy_writing_flag;
    endproperty
    a_locked_range: assert property (p_locked_range) else $error("locked write ran");

    property p_hw_refuse;
        s_done_op(`EWP_OP_STAT_WRITE) ##0 (hw_prot && !busy_writing_flag) |=> !go_q ##1 !busy_writing_flag;
    endproperty
    a_hw_refuse: assert property (p_hw_refuse) else $error("protected status write");

    property p_done_clears;
        wip_done && !(cs_rise && cs_act_q && cmpl_q && cmd_q == `EWP_OP_LATCH_SET)
            |=> !busy_writing_flag && !wel_q;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("end of cycle");

    property p_float_deselect;
        !cs_act_q || !hold_s |-> so_oe_n;
    endproperty
    a_float_deselect: assert property (p_float_deselect) else $error("output driven");

    property p_pause_freeze;
        paused_q && paused_d |=> $stable(bcnt_q) && $stable(sh_q);
    endproperty
    a_pause_freeze: assert property (p_pause_freeze) else $error("moved while paused");

    property p_nv_stable;
        !wip_done |=> $stable(bp_q) && $stable(pen_q);
    endproperty
    a_nv_stable: assert property (p_nv_stable) else $error("protect bits changed");

endmodule : ewp_spi_prot

// [design/ewp_consts.svh]
// constants for the serial eeprom write-protect and status block
`ifndef EWP_CONSTS_SVH
`define EWP_CONSTS_SVH

// ****************************************************
// instruction codes
// ****************************************************
`define EWP_OP_LATCH_SET   8'h06
`define EWP_OP_LATCH_CLR   8'h04
`define EWP_OP_STAT_READ   8'h05
`define EWP_OP_STAT_WRITE  8'h01
`define EWP_OP_ARRAY_WRITE 8'h02

// ****************************************************
// status byte field positions
// ****************************************************
`define EWP_SR_PEN  7
`define EWP_SR_BPHI 3
`define EWP_SR_BPLO 2
`define EWP_SR_WEL  1
`define EWP_SR_WIP  0

// ****************************************************
// protection bases and reset values
// ****************************************************
`define EWP_QUARTER_BASE 10'h300
`define EWP_HALF_BASE    10'h200
`define EWP_PEN_RST      1'b0
`define EWP_BP_RST       2'h0
`define EWP_SYNC_RST     5'h19

// ****************************************************
// timing
// ****************************************************
`define EWP_TWC_US       1000
`define EWP_CLK_KHZ      40000
`define EWP_TWC_CYCLES   ((`EWP_TWC_US * `EWP_CLK_KHZ) / 1000)

`endif

// [design/ewp_pkg.sv]
// types for the serial eeprom write-protect and status block
package ewp_pkg;

    // serial sequence states, one-hot
    typedef enum logic [6:0] {
        EWP_S_STBY = 7'h01,
        EWP_S_OP   = 7'h02,
        EWP_S_ADR  = 7'h04,
        EWP_S_WDAT = 7'h08,
        EWP_S_RDST = 7'h10,
        EWP_S_WSR  = 7'h20,
        EWP_S_SKIP = 7'h40
    } ewp_state_t;

endpackage : ewp_pkg

// [design/ewp_sync.sv]
// two-flop synchroniser for the pin inputs
`timescale 1ns/100ps
`include "ewp_consts.svh"

module ewp_sync (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [4:0] pin_i,
    output logic      [4:0] sync_o
);
    // ****************************************************
    // first stage feeds only the second
    // ****************************************************
    logic [4:0] meta_q;   // first stage
    logic [4:0] sync_q;   // second stage

    // first stage registers the pins, second stage registers the first
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= `EWP_SYNC_RST;
            sync_q <= `EWP_SYNC_RST;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : ewp_sync

// [design/ewp_wtimer.sv]
// self-timed internal write cycle timer
`timescale 1ns/100ps

module ewp_wtimer #(
    parameter int CYCLES = 40000
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic go_i,
    output logic      busy_o,
    output logic      done_o
);
    // ****************************************************
    // cycle counter
    // ****************************************************
    logic [19:0] cnt_q, cnt_d;   // remaining cycles
    logic        busy_q, busy_d; // cycle running
    logic        done_d;         // end pulse, in the last busy cycle

    // next values: load on go, count down, pulse at end
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (busy_q) begin
            if (cnt_q <= 20'h1) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 20'h1;
            end
        end else if (go_i) begin
            busy_d = 1'b1;
            cnt_d  = 20'(CYCLES);
        end
    end

    // registers only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 20'h0;
            busy_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign busy_o = busy_q;
    // combinational so the latch and protect bits change as busy falls
    assign done_o = done_d;

endmodule : ewp_wtimer

// [test/ewp_spi_master.sv]
// spi master model that drives the eeprom pins in mode 0
`timescale 1ns/100ps

module ewp_spi_master (
    input  wire logic sys_clk,
    input  wire logic so_line,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    // ******************************************
    // idle levels
    // ******************************************
    initial begin
        cs_n   = 1'b1;  // deselected from power-up
        sck    = 1'b0;  // clock stands low outside frames
        si     = 1'b0;
        hold_n = 1'b1;  // pause unused unless asked
    end
    // ******************************************
    // frame tasks
    // ******************************************
    // wait n system clocks, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // falling select opens every frame
    task automatic sel();
        tick(1);
        cs_n = 1'b0;
        tick(4);
    endtask : sel
    // select rises only after whole bytes
    task automatic desel();
        tick(4);
        cs_n = 1'b1;
        si   = ~si;  // released line shows no stale bit
        tick(8);
    endtask : desel
    // one byte each way, msb first, set while clock low
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            tick(4);
            rx[i] = so_line;
            sck = 1'b1;
            tick(4);
            sck = 1'b0;
        end
    endtask : xfer
    // pause with clock low, wiggle pins that must be ignored
    task automatic hold_lo(input int n);
        hold_n = 1'b0;
        repeat (2 * n) begin
            tick(4);
            sck = ~sck;
            si  = ~si;
        end
        tick(4);
    endtask : hold_lo
    // resume only while clock is low
    task automatic hold_hi();
        hold_n = 1'b1;
        tick(4);
    endtask : hold_hi
endmodule : ewp_spi_master

// [test/ewp_spi_prot_test.sv]
// self-checking bench for the write-protect and status block
`timescale 1ns/100ps
`include "ewp_consts.svh"

module ewp_spi_prot_test;
    localparam int TWC = 600;  // long enough to read status while busy
    logic       sys_clk, rst_n, nv_rst_n, wp_n_pin, cs_n_pin, sck_pin, si_pin, hold_n_pin;
    logic       so_o, so_oe_n, arr_wr_go;
    logic [9:0] arr_wr_addr, go_addr;
    logic [7:0] status_o, rx;
    int         miscompares, tests_run, go_cnt;
    wire        so_line = so_oe_n ? 1'bz : so_o;  // floating output seen as z

    ewp_spi_prot #(.TWC_CYCLES(TWC)) i_ewp_spi_prot (.sys_clk(sys_clk), .rst_n(rst_n),
        .nv_rst_n(nv_rst_n), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
        .hold_n_pin(hold_n_pin), .wp_n_pin(wp_n_pin), .so_o(so_o), .so_oe_n(so_oe_n),
        .arr_wr_go(arr_wr_go), .arr_wr_addr(arr_wr_addr), .status_o(status_o));
    ewp_spi_master i_ewp_spi_master (.sys_clk(sys_clk), .so_line(so_line), .cs_n(cs_n_pin),
        .sck(sck_pin), .si(si_pin), .hold_n(hold_n_pin));

    // ******************************************
    // clock, reset, watchdog, pulse monitor
    // ******************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #2000000;
        miscompares++;
        stop_test();
    end
    // count start pulses and keep their address
    always @(negedge sys_clk) begin
        if (arr_wr_go === 1'b1) begin
            go_cnt++;
            go_addr = arr_wr_addr;
        end
    end
    // ******************************************
    // shared tasks
    // ******************************************
    task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] op);
        i_ewp_spi_master.sel();
        i_ewp_spi_master.xfer(op, rx);
        i_ewp_spi_master.desel();
    endtask : cmd
    task automatic status_read_cmd();
        i_ewp_spi_master.sel();
        i_ewp_spi_master.xfer(`EWP_OP_STAT_READ, rx);
        i_ewp_spi_master.xfer(8'h00, rx);
        i_ewp_spi_master.desel();
    endtask : status_read_cmd
    task automatic wr_sr(input logic [7:0] d);
        cmd(`EWP_OP_LATCH_SET);
        i_ewp_spi_master.sel();
        i_ewp_spi_master.xfer(`EWP_OP_STAT_WRITE, rx);
        i_ewp_spi_master.xfer(d, rx);
        i_ewp_spi_master.desel();
    endtask : wr_sr
    task automatic wait_idle();
        for (int n = 0; n < 800 && status_o[0] !== 1'b0; n++) i_ewp_spi_master.tick(1);
        check(status_o[0], 1'b0, "write cycle ended");
    endtask : wait_idle
    task automatic arr_wr(input logic [9:0] a, input logic en);
        if (en) cmd(`EWP_OP_LATCH_SET);
        i_ewp_spi_master.sel();
        i_ewp_spi_master.xfer(`EWP_OP_ARRAY_WRITE, rx);
        i_ewp_spi_master.xfer({6'h00, a[9:8]}, rx);
        i_ewp_spi_master.xfer(a[7:0], rx);
        i_ewp_spi_master.xfer(8'h5a, rx);
        i_ewp_spi_master.desel();
        i_ewp_spi_master.tick(4);
        wait_idle();
    endtask : arr_wr
    // ******************************************
    // scenarios
    // ******************************************
    task automatic t_latch();
        check(so_oe_n, 1'b1, "output after reset");
        check(status_o, 8'h00, "status after reset");
        cmd(`EWP_OP_LATCH_SET);
        check(status_o, 8'h02, "latch set");
        cmd(`EWP_OP_LATCH_CLR);
        check(status_o, 8'h00, "latch clear");
        i_ewp_spi_master.sel();
        i_ewp_spi_master.xfer(`EWP_OP_LATCH_SET, rx);
        i_ewp_spi_master.xfer(8'h00, rx);
        i_ewp_spi_master.desel();
        check(status_o, 8'h00, "set without select rise");
    endtask : t_latch
    task automatic t_status();
        int g;
        wr_sr(8'hfc);
        check(status_o, 8'h03, "busy during write");
        status_read_cmd();
        check(rx, 8'h03, "read while busy");
        g = go_cnt;
        arr_wr(10'h000, 1'b1);
        check(10'(go_cnt - g), 10'h000, "array write while busy");
        check(status_o, 8'h8c, "status committed");
        status_read_cmd();
        check(rx, 8'h8c, "status read back");
    endtask : t_status
    task automatic t_hold();
        i_ewp_spi_master.sel();
        i_ewp_spi_master.xfer(`EWP_OP_STAT_READ, rx);
        i_ewp_spi_master.tick(4);
        check(so_oe_n, 1'b0, "driving after opcode");
        i_ewp_spi_master.hold_lo(2);
        check(so_oe_n, 1'b1, "float while paused");
        i_ewp_spi_master.hold_hi();
        i_ewp_spi_master.xfer(8'h00, rx);
        i_ewp_spi_master.desel();
        check(rx, 8'h8c, "read across pause");
        check(so_oe_n, 1'b1, "float when deselected");
    endtask : t_hold
    task automatic t_wp();
        wp_n_pin = 1'b0;
        wr_sr(8'h00);
        wait_idle();
        check(status_o, 8'h8e, "write refused by pin");
        cmd(`EWP_OP_LATCH_CLR);
        check(status_o, 8'h8c, "clear under pin lock");
        wp_n_pin = 1'b1;
        wr_sr(8'h84);
        wp_n_pin = 1'b0;
        wait_idle();
        check(status_o, 8'h84, "pin fall after start");
        wp_n_pin = 1'b1;
        wr_sr(8'h00);
        wait_idle();
        wp_n_pin = 1'b0;
        wr_sr(8'h08);
        wait_idle();
        check(status_o, 8'h08, "pin ignored when disabled");
        wp_n_pin = 1'b1;
    endtask : t_wp
    task automatic t_array();
        logic [9:0] adr [6] = '{10'h000, 10'h1ff, 10'h200, 10'h2ff, 10'h300, 10'h3ff};
        logic       ok;
        int         g;
        for (int c = 0; c < 4; c++) begin
            wr_sr({4'h0, 2'(c), 2'h0});
            wait_idle();
            for (int i = 0; i < 6; i++) begin
                ok = (c == 0) || (c == 1 && adr[i] < 10'h300) || (c == 2 && adr[i] < 10'h200);
                g = go_cnt;
                arr_wr(adr[i], 1'b1);
                check(10'(go_cnt - g), {9'h000, ok}, "array start by code");
                check(status_o[1], !ok, "latch after array write");
                if (ok) check(go_addr, adr[i], "array start address");
            end
        end
        cmd(`EWP_OP_LATCH_CLR);
        g = go_cnt;
        arr_wr(10'h000, 1'b0);
        check(10'(go_cnt - g), 10'h000, "array write with latch clear");
    endtask : t_array
    // ******************************************
    // main sequence and verdict
    // ******************************************
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        rst_n    = 1'b0;
        nv_rst_n = 1'b0;
        wp_n_pin = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        rst_n    = 1'b1;
        nv_rst_n = 1'b1;
        i_ewp_spi_master.tick(4);
        t_latch();
        t_status();
        t_hold();
        t_wp();
        t_array();
        stop_test();
    end
endmodule : ewp_spi_prot_test
